// ---- spd_spi_slave.sv ----
// Serial slave with frame check, diagnosis control and standard diagnosis
//
// Operation
// - Chip select high: ignore clock, input; output off
// - Select fall starts access, select rise ends
// - Sample input on clock fall, update output on rise
// - Most significant bit first; control then data
// - Select fall loads requested response into shifter
// - Before first clock rise, output error OR input
// - Decode only after nonzero multiple of eight clocks
// - Bad count sets error flag, discards command
// - Good frame copies shifter into addressed register
// - Eight-bit shifter passes data down the chain
// - Control frame: top ones, selection, bypass readback
// - Channel on: codes zero-five route sense, six off
// - Channel off: sense off; code seven is standby
// - Bypass bit reflects threshold, invalid in standby
`timescale 1ns/1ps
module spd_spi_slave
    import spd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Serial pins
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    // Power stage status
    input wire logic [5:0] channel_output_state_in,
    input wire logic [5:0] channel_error_flag_in,
    input wire logic high_side_indication_in,
    input wire logic bypass_monitor_in,
    // Current sense routing
    output logic sense_route_en_out,
    output logic [2:0] sense_channel_out,
    output logic standby_out,
    // Accepted frames towards the command registers
    output logic [7:0] frame_data_out,
    output logic frame_valid_out,
    input wire logic frame_ready_in,
    // Status
    output logic transfer_error_flag_out
);
    // Only the system clock runs logic here; the serial clock is just
    // another sampled pin, so there is a single clock domain.

    // Frame address field check
    function automatic logic is_diag_ctrl(input logic [7:0] word);
        is_diag_ctrl = (word[ADDR_HI:ADDR_LO] == DIAG_CTRL_ADDR);
    endfunction

    // Next value of the modulo-8 bit counter
    function automatic logic [2:0] cnt_inc(input logic [2:0] cnt);
        cnt_inc = cnt + 3'h1;
    endfunction

    // Control readback word; unused bit 4 reads zero
    function automatic logic [7:0] ctrl_word(input logic bypass, input logic [2:0] sel);
        ctrl_word = {DIAG_CTRL_ADDR, 1'b0, bypass, sel};
    endfunction

    // Sense is routed only for a channel code whose output is on
    function automatic logic sense_routed(input logic [2:0] sel, input logic [5:0] on_state);
        if (sel <= SEL_LAST_CHANNEL) begin
            sense_routed = on_state[sel];
        end else begin
            sense_routed = 1'b0;
        end
    endfunction

    // Synchronisers
    // Pins are seen three clocks late: two stages plus the edge compare
    // Trade-off: plain sampling limits the link clock to a few MHz
    // All pins share one delay, so data and clock keep their order
    logic [ASYNC_W-1:0] meta_reg;
    logic [ASYNC_W-1:0] sync_reg;
    logic cs_prev_reg;
    logic sclk_prev_reg;

    // Access state
    // Lead phase: from select fall to the first clock rise
    // Shift phase: until select rises again
    spd_phase_t phase_reg;
    spd_phase_t phase_next;
    logic [7:0] shift_reg;
    logic [2:0] count_reg;
    logic seen8_reg;
    logic transfer_error_flag_reg;
    logic transfer_error_flag_next;
    logic so_reg;
    logic so_oe_reg;

    // Register file
    // Selection resets to standby, so no sense is routed at power up
    // Readback choice decides which word the next access returns
    logic [2:0] sense_select_reg;
    logic readback_select_reg;
    logic sense_route_en_reg;
    logic [2:0] sense_channel_reg;
    logic standby_reg;

    // Carriers to and from the buffer
    // Two entries let the consumer stall for one whole access
    spd_stream_if #(.W(BUF_W)) rx_if ();
    spd_stream_if #(.W(BUF_W)) out_if ();

    // Synchronised views; the first stage is read only by the second
    wire cs_n_s = sync_reg[IX_CS];
    wire sclk_s = sync_reg[IX_SCLK];
    wire si_s = sync_reg[IX_SI];
    wire [5:0] out_state_s = sync_reg[IX_OUT_HI:IX_OUT_LO];
    wire [5:0] chan_err_s = sync_reg[IX_ERR_HI:IX_ERR_LO];
    wire hsi_s = sync_reg[IX_HSI];
    wire bypass_s = sync_reg[IX_BYPASS];

    // Pin edges; clock and data only count while selected
    // Selected needs two low samples, so a select glitch passes no clock or data edge
    wire cs_fall = cs_prev_reg & ~cs_n_s;
    wire cs_rise = ~cs_prev_reg & cs_n_s;
    wire selected = ~cs_n_s & ~cs_prev_reg;
    wire sclk_fall = selected & sclk_prev_reg & ~sclk_s;
    wire sclk_rise = selected & ~sclk_prev_reg & sclk_s;

    // Frame check at the end of access
    // Counter wraps every eight clocks; seen8 rules out an empty frame
    // A frame meeting a full buffer is refused rather than overwriting
    wire frame_ok = cs_rise & seen8_reg & (count_reg == CNT_ZERO);
    wire accept = frame_ok & rx_if.ready;
    wire [7:0] rx_word = shift_reg;
    wire ctrl_frame = is_diag_ctrl(rx_word);
    wire ctrl_write = accept & ctrl_frame & ~rx_word[DIAG_BYPASS_BIT];

    // Standby makes the bypass readback meaningless, so report zero
    // Limitation: a master cannot tell zero from invalid in standby
    wire standby_now = (sense_select_reg == SEL_STANDBY);
    wire bypass_bit = bypass_s & ~standby_now;

    // Response words
    // Chosen at select fall, so later status shows in the next access
    // Nothing here waits on the link clock, only on synchronised levels
    wire [7:0] diag_ctrl_word = ctrl_word(bypass_bit, sense_select_reg);
    wire [7:0] std_diag_word = {1'b0, hsi_s, chan_err_s};
    wire [7:0] resp_word = readback_select_reg ? diag_ctrl_word : std_diag_word;

    // Sense routing decode from selection and channel state
    // Code six and standby never route, whatever the channel does
    wire route_next = sense_routed(sense_select_reg, out_state_s);

    // Buffer hookup; a full buffer rejects the frame as a bad transfer
    // Valid may rise while full; a push needs ready as well
    assign rx_if.valid = frame_ok;
    assign rx_if.data = rx_word;
    assign out_if.ready = frame_ready_in;
    assign frame_data_out = out_if.data;
    assign frame_valid_out = out_if.valid;

    // Two flip-flops on every asynchronous input
    // Status pins are slow independent levels; a bit caught mid-change
    // only moves its report to the next access
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= SYNC_RST;
            sync_reg <= SYNC_RST;
        end else begin
            meta_reg <= {cs_n_in, sclk_in, si_in, channel_output_state_in,
                         channel_error_flag_in, high_side_indication_in,
                         bypass_monitor_in};
            sync_reg <= meta_reg;
        end
    end

    // Previous levels for edge detection
    // Reset values equal the idle pin levels, so no false edge follows
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_n_s;
            sclk_prev_reg <= sclk_s;
        end
    end

    // Access phase sequencing
    // A select rise in any phase ends the access; clock edges outside
    // an access never reach this logic
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            SPD_IDLE: begin
                if (cs_fall) begin
                    phase_next = SPD_LEAD;
                end
            end
            SPD_LEAD: begin
                if (cs_rise) begin
                    phase_next = SPD_IDLE;
                end else if (sclk_rise) begin
                    phase_next = SPD_SHIFT;
                end
            end
            SPD_SHIFT: begin
                if (cs_rise) begin
                    phase_next = SPD_IDLE;
                end
            end
            default: begin
                phase_next = SPD_IDLE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_reg <= SPD_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Shifter: load on select fall, MSB out, input in at the bottom
    // After eight clocks the old bits have left through the output,
    // which lets a chain of devices share one select
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg <= WORD_RST;
        end else if (cs_fall) begin
            shift_reg <= resp_word;
        end else if (sclk_fall) begin
            shift_reg <= {shift_reg[6:0], si_s};
        end
    end

    // Modulo-8 clock counter plus a flag for at least one full byte
    // Only falling clock edges count, matching the sampling edge
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg <= CNT_ZERO;
            seen8_reg <= 1'b0;
        end else if (cs_fall) begin
            count_reg <= CNT_ZERO;
            seen8_reg <= 1'b0;
        end else if (sclk_fall) begin
            count_reg <= cnt_inc(count_reg);
            seen8_reg <= seen8_reg | (count_reg == CNT_LAST);
        end
    end

    // Error flag: a refused frame sets it, a good one clears it
    // Set and clear both happen on a select rise, never together
    // The flag stays set across any number of refused frames
    always_comb begin
        transfer_error_flag_next = transfer_error_flag_reg;
        if (cs_rise) begin
            if (accept) begin
                transfer_error_flag_next = 1'b0;
            end else begin
                transfer_error_flag_next = 1'b1;
            end
        end
    end

    // Error flag register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            transfer_error_flag_reg <= TER_RST;
        end else begin
            transfer_error_flag_reg <= transfer_error_flag_next;
        end
    end

    // Serial output: error OR input in lead phase, then shifter MSB
    // In lead phase the output follows the input every cycle, so an
    // upstream error reaches the master through the whole chain
    // Driven low when released; the enable marks it invalid anyway
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            so_oe_reg <= (phase_next != SPD_IDLE);
            if (phase_next == SPD_LEAD) begin
                so_reg <= transfer_error_flag_reg | si_s;
            end else if (sclk_rise) begin
                so_reg <= shift_reg[7];
            end else if (phase_next == SPD_IDLE) begin
                so_reg <= 1'b0;
            end
        end
    end

    // Addressed registers update only on an accepted frame
    // A read-only control frame keeps the selection but still asks
    // for the control word in the next access
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sense_select_reg <= SENSE_SELECT_RST;
            readback_select_reg <= READBACK_RST;
        end else begin
            if (ctrl_write) begin
                sense_select_reg <= rx_word[SEL_HI:SEL_LO];
            end
            if (accept) begin
                readback_select_reg <= ctrl_frame;
            end
        end
    end

    // Registered sense routing; standby and code six keep it off
    // One clock behind the selection; the analog side settles far
    // slower, so the extra cycle costs nothing
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sense_route_en_reg <= 1'b0;
            sense_channel_reg <= SEL_SENSE_OFF;
            standby_reg <= 1'b1;
        end else begin
            sense_route_en_reg <= route_next;
            sense_channel_reg <= sense_select_reg;
            standby_reg <= standby_now;
        end
    end

    // Accepted frames wait here if the consumer stalls
    // The consumer sees frames in arrival order, oldest first
    spd_buf u_buf (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .fill(rx_if.snk),
        .drain(out_if.src)
    );

    // Outputs
    // All outputs come from flip-flops or buffer storage
    assign so_out = so_reg;
    assign so_oe_out = so_oe_reg;
    assign sense_route_en_out = sense_route_en_reg;
    assign sense_channel_out = sense_channel_reg;
    assign standby_out = standby_reg;
    assign transfer_error_flag_out = transfer_error_flag_reg;
endmodule

// ---- spd_pkg.sv ----
// Shared constants for the serial diagnosis and control slave
package spd_pkg;
    // Frame geometry
    localparam int FRAME_BITS = 8;
    localparam int CNT_W = 3;
    localparam logic [2:0] CNT_LAST = 3'h7;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    // Address field of a frame
    localparam int ADDR_HI = 7;
    localparam int ADDR_LO = 5;
    localparam logic [2:0] DIAG_CTRL_ADDR = 3'h7;
    // Diagnosis control field positions
    localparam int DIAG_BYPASS_BIT = 3;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 0;
    // Sense select codes
    localparam logic [2:0] SEL_LAST_CHANNEL = 3'h5;
    localparam logic [2:0] SEL_SENSE_OFF = 3'h6;
    localparam logic [2:0] SEL_STANDBY = 3'h7;
    localparam logic [2:0] SENSE_SELECT_RST = 3'h7;
    // Standard diagnosis word layout
    localparam int STD_ZERO_BIT = 7;
    localparam int STD_HSI_BIT = 6;
    localparam int CHANNELS = 6;
    // Reset values
    localparam logic TER_RST = 1'b0;
    localparam logic READBACK_RST = 1'b0;
    localparam logic [7:0] WORD_RST = 8'h00;
    // Synchroniser vector: cs, sclk, si, out state, errors, hsi, bypass
    localparam int ASYNC_W = 17;
    localparam int IX_CS = 16;
    localparam int IX_SCLK = 15;
    localparam int IX_SI = 14;
    localparam int IX_OUT_HI = 13;
    localparam int IX_OUT_LO = 8;
    localparam int IX_ERR_HI = 7;
    localparam int IX_ERR_LO = 2;
    localparam int IX_HSI = 1;
    localparam int IX_BYPASS = 0;
    localparam logic [16:0] SYNC_RST = 17'h1_0000;
    // Two-entry buffer
    localparam int BUF_W = 8;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    // Access phases, Gray along idle -> lead -> shift
    typedef enum logic [1:0] {
        SPD_IDLE = 2'b00,
        SPD_LEAD = 2'b01,
        SPD_SHIFT = 2'b11
    } spd_phase_t;
endpackage

// ---- spd_stream_if.sv ----
// Valid/ready word carrier between the slave and its buffer
`timescale 1ns/1ps
interface spd_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- spd_buf.sv ----
// Two-entry buffer for accepted frames
`timescale 1ns/1ps
module spd_buf
    import spd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Filling and draining sides
    spd_stream_if.snk fill,
    spd_stream_if.src drain
);
    logic [BUF_W-1:0] mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    wire push = fill.valid & fill.ready;
    wire pop = drain.valid & drain.ready;

    // Full and empty straight from the occupancy count
    assign fill.ready = (count_reg != BUF_FULL);
    assign drain.valid = (count_reg != BUF_EMPTY);
    assign drain.data = mem_reg[rd_ptr_reg];
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

    // Storage needs no reset; valid gates it
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= fill.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= BUF_EMPTY;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_next;
        end
    end
endmodule

// ---- spd_spi_slave_assertions.sv ----
// Port-level checks of the serial slave
`timescale 1ns/1ps
module spd_spi_slave_assertions (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Watched ports
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic so_out,
    input wire logic so_oe_out,
    input wire logic sense_route_en_out,
    input wire logic standby_out,
    input wire logic [7:0] frame_data_out,
    input wire logic frame_valid_out,
    input wire logic frame_ready_in,
    input wire logic transfer_error_flag_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Output released once select has stayed high past the sync delay
    property p_idle_off; cs_n_in [*6] |-> !so_oe_out; endproperty
    a_idle_off: assert property (p_idle_off) else $error("so driven while idle");
    property p_oe_fall; $fell(so_oe_out) |-> cs_n_in; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("so released while selected");
    property p_oe_on; $fell(cs_n_in) |-> ##[2:5] so_oe_out; endproperty
    a_oe_on: assert property (p_oe_on) else $error("so not driven after select");
    // Lead phase level is error flag OR input
    property p_lead; $rose(so_oe_out) |-> so_out == (transfer_error_flag_out | si_in); endproperty
    a_lead: assert property (p_lead) else $error("lead level wrong");
    property p_standby; standby_out && $past(standby_out) |-> !sense_route_en_out; endproperty
    a_standby: assert property (p_standby) else $error("sense routed in standby");
    // Frames only pushed and flag only moved after select rises
    property p_push; $rose(frame_valid_out) |-> cs_n_in; endproperty
    a_push: assert property (p_push) else $error("frame pushed while selected");
    property p_hold; frame_valid_out && !frame_ready_in |=> frame_valid_out && $stable(frame_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word lost");
    property p_ter_idle; $changed(transfer_error_flag_out) |-> cs_n_in; endproperty
    a_ter_idle: assert property (p_ter_idle) else $error("flag moved mid access");
    property p_ter_nopush; $rose(transfer_error_flag_out) |-> !$rose(frame_valid_out); endproperty
    a_ter_nopush: assert property (p_ter_nopush) else $error("refused frame pushed");
endmodule

bind spd_spi_slave spd_spi_slave_assertions u_chk (.ref_clk_in, .reset_n_in, .cs_n_in, .si_in,
    .so_out, .so_oe_out, .sense_route_en_out, .standby_out, .frame_data_out, .frame_valid_out,
    .frame_ready_in, .transfer_error_flag_out);

// ---- spd_master_model.sv ----
// Serial master model driving the slave pins
`timescale 1ns/1ps
module spd_master_model (
    // Serial pins
    output logic cs_n_out,
    output logic sclk_out,
    output logic si_out,
    input wire logic so_in
);
    localparam time GAP = 1000;
    // Idle levels follow the pin pulls
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
    end
    // One access of n clocks at half period hp; lead is the level before clocking
    task automatic xfer(input int n, input logic [15:0] tx, input logic lsi, input time hp,
            output logic lead, output logic [15:0] rx);
        rx = 16'h0000;
        si_out = lsi;
        #hp;
        cs_n_out = 1'b0;
        #GAP;
        lead = so_in;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out = 1'b1;
            si_out = tx[i];
            #hp;
            sclk_out = 1'b0;
            #hp;
            rx = {rx[14:0], so_in};
        end
        #GAP;
        cs_n_out = 1'b1;
        si_out = 1'b0;
        #GAP;
    endtask
endmodule

// ---- spd_spi_slave_tb.sv ----
// Self-checking bench for the serial slave
`timescale 1ns/1ps
module spd_spi_slave_tb;
    import spd_pkg::*;
    typedef struct packed {
        logic [7:0] tx;
        logic [5:0] on;
        logic route;
        logic stby;
    } spd_row_t;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cs_n, sclk, si, so, so_oe, so_line, route, stby, fvalid, transfer_error_flag, lead;
    logic ready = 1'b0;
    logic [5:0] on_st = 6'h3f;
    logic [5:0] err = 6'h2a;
    logic hsi = 1'b1;
    logic byp = 1'b1;
    logic [2:0] sch, psel;
    logic [7:0] fdata, exp_r;
    logic [15:0] rx;
    int error_cnt = 0;
    int samples_checked = 0;
    // Selection codes with channel states and the routing they give
    spd_row_t rows [9] = '{'{8'he0, 6'h3f, 1'b1, 1'b0}, '{8'he1, 6'h3f, 1'b1, 1'b0},
        '{8'he2, 6'h3f, 1'b1, 1'b0}, '{8'he3, 6'h3f, 1'b1, 1'b0}, '{8'he4, 6'h3f, 1'b1, 1'b0},
        '{8'he5, 6'h3f, 1'b1, 1'b0}, '{8'he6, 6'h3f, 1'b0, 1'b0}, '{8'he7, 6'h3f, 1'b0, 1'b1},
        '{8'he3, 6'h37, 1'b0, 1'b0}};
    always #2.5 ref_clk_in = ~ref_clk_in;
    // Line level seen by the master
    assign so_line = so_oe ? so : 1'bz;
    spd_spi_slave u_dut (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si), .so_out(so), .so_oe_out(so_oe),
        .channel_output_state_in(on_st), .channel_error_flag_in(err),
        .high_side_indication_in(hsi), .bypass_monitor_in(byp),
        .sense_route_en_out(route), .sense_channel_out(sch), .standby_out(stby),
        .frame_data_out(fdata), .frame_valid_out(fvalid), .frame_ready_in(ready),
        .transfer_error_flag_out(transfer_error_flag)
    );
    spd_master_model u_master (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so_line));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic go(input int n, input logic [15:0] tx, input logic lsi, input time hp);
        u_master.xfer(n, tx, lsi, hp, lead, rx);
        @(negedge ref_clk_in);
    endtask
    // One-cycle pop of the oldest buffered word
    task automatic pop;
        @(negedge ref_clk_in) ready = 1'b1;
        @(negedge ref_clk_in) ready = 1'b0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: a hang counts against the run
    initial begin
        #400us;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (16) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        check({so_oe, transfer_error_flag, fvalid, stby}, 4'h1);
        // Every selection code, read back on the following access
        foreach (rows[i]) begin
            exp_r = {3'h7, 1'b0, byp & (psel != SEL_STANDBY), psel};
            if (i == 0) begin
                exp_r = {1'b0, hsi, err};
            end
            psel = rows[i].tx[2:0];
            on_st = rows[i].on;
            go(8, {8'h00, rows[i].tx}, 1'b0, 32);
            check(rx[7:0], exp_r);
            check({route, sch, stby}, {rows[i].route, psel, rows[i].stby});
            check({fvalid, fdata}, {1'b1, rows[i].tx});
            pop;
        end
        $display("done: selection table");
        // Read-only control frame, then standard word
        on_st = 6'h3f;
        go(8, 16'h00e8, 1'b0, 32);
        check(sch, 3'h3);
        pop;
        go(8, 16'h0015, 1'b0, 32);
        check(rx[7:0], 8'heb);
        go(8, 16'h0015, 1'b0, 300);
        check({transfer_error_flag, rx[7:0]}, {1'b0, 8'h6a});
        repeat (2) pop;
        $display("done: read and standard word");
        // Bad counts, flag reported then cleared
        go(5, 16'h00e1, 1'b0, 32);
        check({transfer_error_flag, fvalid, sch}, {2'b10, 3'h3});
        go(0, 16'h0000, 1'b0, 32);
        check(transfer_error_flag, 1'b1);
        go(8, 16'h0015, 1'b0, 32);
        check({lead, transfer_error_flag, rx[7:0]}, {2'b10, 8'h6a});
        go(8, 16'h0015, 1'b1, 300);
        check(lead, 1'b1);
        repeat (2) pop;
        $display("done: framing errors");
        // One device clocked sixteen times, as in a two-device chain
        go(16, 16'h33e2, 1'b0, 32);
        check({rx[7:0], sch}, {8'h33, 3'h2});
        pop;
        $display("done: chain");
        // Full buffer refuses the third frame
        go(8, 16'h0011, 1'b0, 32);
        go(8, 16'h0022, 1'b0, 32);
        go(8, 16'h0044, 1'b0, 32);
        check({transfer_error_flag, fdata}, {1'b1, 8'h11});
        pop;
        check(fdata, 8'h22);
        pop;
        check(fvalid, 1'b0);
        $display("done: buffer");
        // Reset in mid-run, then new status levels after it
        reset_n_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check({so_oe, transfer_error_flag, fvalid, stby}, 4'h1);
        reset_n_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        check({stby, sch}, {1'b1, 3'h7});
        hsi = 1'b0;
        err = 6'h15;
        byp = 1'b0;
        go(8, 16'h00e2, 1'b0, 32);
        check({rx[7:0], sch, stby}, {8'h15, 3'h2, 1'b0});
        go(8, 16'h00e8, 1'b0, 32);
        check(rx[7:0], 8'he2);
        repeat (2) pop;
        check(fvalid, 1'b0);
        $display("done: reset");
        final_report;
    end
endmodule
